// File: bench/rfa_bank_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rfa_bank_properties #(
  parameter [31:0] BASE_ADDR = 32'h4000_0000,
  parameter [7:0] CTRL_RST = 8'h00,
  parameter [7:0] ID_VAL = 8'h5A
) (
  input wire clk_in,
  input wire nrst_in,
  input wire [31:0] addr_in,
  input wire wr_in,
  input wire rd_in,
  input wire [31:0] wdata_in,
  input wire [7:0] event_in,
  input wire [7:0] fault_in,
  input wire [7:0] ack_in,
  input wire [31:0] rdata_out,
  input wire rvalid_out,
  input wire [7:0] ctrl_out,
  input wire [7:0] arm_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  wire [31:0] o = addr_in - BASE_ADDR;
  unmap_rd_a: assert property (rd_in && o == 32'h100 |=> rdata_out == 32'h0)
    else $error("unmapped read");
  ctrl_hold_a: assert property (!(wr_in && o == 32'h0) |=> $stable(ctrl_out))
    else $error("ctrl changed");
  ctrl_wr_a: assert property (wr_in && o == 32'h0 |=> ctrl_out == $past(wdata_in[7:0]))
    else $error("ctrl write");
  ctrl_rd_a: assert property (
    rd_in && o == 32'h0 |=> rdata_out == {16'h0, ID_VAL, $past(ctrl_out)})
    else $error("ctrl read");
  arm_set_a: assert property (wr_in && o == 32'h10 && ack_in == 8'h0 |=>
    arm_out == ($past(arm_out) | $past(wdata_in[7:0]))) else $error("arm set");
  arm_rd_a: assert property (rd_in && o == 32'h10 |=> rdata_out == {24'h0, $past(arm_out)})
    else $error("arm read");
  clr_rd_a: assert property (rd_in && o == 32'h14 |=> rdata_out == 32'h0)
    else $error("clear read");
  rst_val_a: assert property ($rose(nrst_in) |-> ctrl_out == CTRL_RST && arm_out == 8'h0)
    else $error("reset value");
  rvalid_pulse_a: assert property (rvalid_out == $past(rd_in))
    else $error("read valid timing");
  cover property (rd_in && o == 32'h4);
  cover property (rd_in && o == 32'h8);
  cover property (wr_in && o == 32'h10);
endmodule
bind rfa_bank rfa_bank_properties #(.BASE_ADDR(BASE_ADDR), .CTRL_RST(CTRL_RST), .ID_VAL(ID_VAL))
  i_rfa_bank_properties (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wr_in(wr_in),
    .rd_in(rd_in), .wdata_in(wdata_in), .event_in(event_in), .fault_in(fault_in),
    .ack_in(ack_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out), .ctrl_out(ctrl_out),
    .arm_out(arm_out));
`default_nettype wire

// File: bench/rfa_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rfa_bank_tb;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] event_in = 8'h00;
  logic [7:0] fault_in = 8'h00;
  logic [7:0] ack_in = 8'h00;
  wire [31:0] addr_in, wdata_in, rdata_out;
  wire wr_in, rd_in, rvalid_out;
  wire [7:0] ctrl_out, arm_out;
  int error_cnt = 0;
  int checks_done = 0;
  logic [31:0] q;
  always #12.5 clk_in = ~clk_in;
  rfa_bank i_rfa_bank (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wr_in(wr_in),
    .rd_in(rd_in), .wdata_in(wdata_in), .event_in(event_in), .fault_in(fault_in),
    .ack_in(ack_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out), .ctrl_out(ctrl_out),
    .arm_out(arm_out));
  rfa_sw_model i_rfa_sw_model (.clk_in(clk_in), .rvalid_in(rvalid_out), .rdata_in(rdata_out),
    .addr_out(addr_in), .wr_out(wr_in), .rd_out(rd_in), .wdata_out(wdata_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_r(input logic [11:0] o, input logic [31:0] d);
    i_rfa_sw_model.acc(1'b1, o, d, q);
  endtask
  task automatic rd_c(input logic [11:0] o, input logic [31:0] e);
    i_rfa_sw_model.acc(1'b0, o, 32'h0, q);
    chk(q, e);
  endtask
  task automatic hw(input logic [7:0] e, input logic [7:0] f, input logic [7:0] a);
    @(posedge clk_in);
    #1;
    {event_in, fault_in, ack_in} = {e, f, a};
    @(posedge clk_in);
    #1;
    {event_in, fault_in, ack_in} = 24'h0;
  endtask
  task automatic t_ctrl;
    rd_c(12'h000, 32'h5A00);
    wr_r(12'h000, 32'h5AA5);
    rd_c(12'h000, 32'h5AA5);
    chk({24'h0, ctrl_out}, 32'hA5);
    wr_r(12'h100, 32'hFF);
    rd_c(12'h100, 32'h0);
    rd_c(12'h000, 32'h5AA5);
  endtask
  task automatic t_stat;
    hw(8'h0F, 8'h33, 8'h00);
    rd_c(12'h004, 32'h0F);
    wr_r(12'h004, 32'h05);
    rd_c(12'h004, 32'h0A);
    wr_r(12'h014, 32'h02);
    rd_c(12'h004, 32'h08);
    rd_c(12'h014, 32'h0);
    rd_c(12'h008, 32'h0F);
    rd_c(12'h008, 32'h0);
    rd_c(12'h00C, 32'h33);
    wr_r(12'h00C, 32'h0);
    rd_c(12'h00C, 32'h0);
    hw(8'h01, 8'h00, 8'h00);
    rd_c(12'h004, 32'h09);
    hw(8'h10, 8'h00, 8'h00);
    wr_r(12'h004, 32'h09);
    rd_c(12'h004, 32'h10);
  endtask
  task automatic t_arm;
    wr_r(12'h010, 32'h05);
    wr_r(12'h010, 32'h02);
    chk({24'h0, arm_out}, 32'h07);
    hw(8'h00, 8'h00, 8'h01);
    rd_c(12'h010, 32'h06);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    #1;
    nrst_in = 1'b1;
    t_ctrl;
    t_stat;
    t_arm;
    print_verdict;
  end
endmodule
`default_nettype wire

// File: bench/rfa_sw_model.sv
`timescale 1ns/1ps
`default_nettype none
module rfa_sw_model #(
  parameter [31:0] BASE_ADDR = 32'h4000_0000
) (
  input wire logic clk_in,
  input wire logic rvalid_in,
  input wire logic [31:0] rdata_in,
  output logic [31:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [31:0] wdata_out
);
  initial begin
    addr_out = 32'h0;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 32'h0;
  end
  // One access; address and data lines inverted and strobes dropped once released
  task automatic acc(input logic w, input logic [11:0] off, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_in);
    #1;
    addr_out = BASE_ADDR + {20'h0, off};
    wdata_out = d;
    wr_out = w;
    rd_out = !w;
    @(posedge clk_in);
    #1;
    q = (rvalid_in === 1'b1) ? rdata_in : 32'hX;
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = ~addr_out;
    wdata_out = ~wdata_out;
  endtask
endmodule
`default_nettype wire

// File: design/rfa_bank.v
`timescale 1ns/1ps
`default_nettype none
`include "rfa_defines.vh"

module rfa_bank #(
  parameter [31:0] BASE_ADDR = 32'h4000_0000,
  parameter [7:0] CTRL_RST = 8'h00,
  parameter [7:0] ID_VAL = 8'h5A
) (
  input wire clk_in,
  input wire nrst_in,
  input wire [31:0] addr_in,
  input wire wr_in,
  input wire rd_in,
  input wire [31:0] wdata_in,
  input wire [7:0] event_in,
  input wire [7:0] fault_in,
  input wire [7:0] ack_in,
  output reg [31:0] rdata_out,
  output reg rvalid_out,
  output wire [7:0] ctrl_out,
  output wire [7:0] arm_out
);

  localparam W = `RFA_FLD_HI - `RFA_FLD_LO + 1;

  // ****************************************
  // Address decode
  // ****************************************
  wire [31:0] rel_addr;
  assign rel_addr = addr_in - BASE_ADDR;

  function hit;
    input [31:0] rel;
    input [`RFA_OFF_W-1:0] off;
    begin
      hit = (rel == {20'h0_0000, off});
    end
  endfunction

  wire sel_ctrl;
  wire sel_stat;
  wire sel_seen;
  wire sel_accum;
  wire sel_arm;
  wire sel_clear;
  assign sel_ctrl = hit(rel_addr, `RFA_OFF_CTRL);
  assign sel_stat = hit(rel_addr, `RFA_OFF_STAT);
  assign sel_seen = hit(rel_addr, `RFA_OFF_SEEN);
  assign sel_accum = hit(rel_addr, `RFA_OFF_ACCUM);
  assign sel_arm = hit(rel_addr, `RFA_OFF_ARM);
  assign sel_clear = hit(rel_addr, `RFA_OFF_CLEAR);

  wire [W-1:0] ctrl_q;
  wire [W-1:0] id_q;
  wire [W-1:0] stat_q;
  wire [W-1:0] seen_q;
  wire [W-1:0] accum_q;
  wire [W-1:0] arm_q;

  // ****************************************
  // Field cells
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      rfa_field #(.KIND(`RFA_T_RW), .RST_VAL(CTRL_RST[i])) u_ctrl (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .wr_in(wr_in && sel_ctrl),
        .rd_in(1'b0),
        .wbit_in(wdata_in[`RFA_FLD_LO + i]),
        .hw_set_in(1'b0),
        .hw_clr_in(1'b0),
        .q_out(ctrl_q[i])
      );

      // Read-only identity field ignores writes
      rfa_field #(.KIND(`RFA_T_RO), .RST_VAL(ID_VAL[i])) u_id (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .wr_in(wr_in && sel_ctrl),
        .rd_in(1'b0),
        .wbit_in(wdata_in[`RFA_ID_LO + i]),
        .hw_set_in(1'b0),
        .hw_clr_in(1'b0),
        .q_out(id_q[i])
      );
    end

    // ****************************************
    // Event-driven status cells
    // ****************************************
    for (i = 0; i < W; i = i + 1) begin : g_evt
      // Status cleared by write-back or by the write-only clear register
      rfa_field #(.KIND(`RFA_T_W1C), .RST_VAL(`RFA_RST_ZERO)) u_stat (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .wr_in(wr_in && (sel_stat || sel_clear)),
        .rd_in(1'b0),
        .wbit_in(wdata_in[`RFA_FLD_LO + i]),
        .hw_set_in(event_in[i]),
        .hw_clr_in(1'b0),
        .q_out(stat_q[i])
      );

      rfa_field #(.KIND(`RFA_T_RC), .RST_VAL(`RFA_RST_ZERO)) u_seen (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .wr_in(1'b0),
        .rd_in(rd_in && sel_seen),
        .wbit_in(1'b0),
        .hw_set_in(event_in[i]),
        .hw_clr_in(1'b0),
        .q_out(seen_q[i])
      );

      rfa_field #(.KIND(`RFA_T_RWC), .RST_VAL(`RFA_RST_ZERO)) u_accum (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .wr_in(wr_in && sel_accum),
        .rd_in(1'b0),
        .wbit_in(wdata_in[`RFA_FLD_LO + i]),
        .hw_set_in(fault_in[i]),
        .hw_clr_in(1'b0),
        .q_out(accum_q[i])
      );

      rfa_field #(.KIND(`RFA_T_W1S), .RST_VAL(`RFA_RST_ZERO)) u_arm (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .wr_in(wr_in && sel_arm),
        .rd_in(1'b0),
        .wbit_in(wdata_in[`RFA_FLD_LO + i]),
        .hw_set_in(1'b0),
        .hw_clr_in(ack_in[i]),
        .q_out(arm_q[i])
      );
    end
  endgenerate

  // ****************************************
  // Register read words
  // ****************************************
  function [31:0] place_fld;
    input [W-1:0] fld;
    input integer lo;
    begin
      place_fld = `RFA_DATA_ZERO;
      place_fld[lo +: W] = fld;
    end
  endfunction

  wire [31:0] ctrl_word;
  wire [31:0] stat_word;
  wire [31:0] seen_word;
  wire [31:0] accum_word;
  wire [31:0] arm_word;
  wire [31:0] clear_word;

  assign ctrl_word = place_fld(ctrl_q, `RFA_FLD_LO) | place_fld(id_q, `RFA_ID_LO);
  assign stat_word = place_fld(stat_q, `RFA_FLD_LO);
  assign seen_word = place_fld(seen_q, `RFA_FLD_LO);
  assign accum_word = place_fld(accum_q, `RFA_FLD_LO);
  assign arm_word = place_fld(arm_q, `RFA_FLD_LO);
  assign clear_word = `RFA_DATA_ZERO;

  // ****************************************
  // Output drive
  // ****************************************
  assign ctrl_out = ctrl_q;
  assign arm_out = arm_q;

  // ****************************************
  // Read data mux
  // ****************************************
  reg [31:0] rdata_next;

  always @* begin
    rdata_next = `RFA_DATA_ZERO;
    if (sel_ctrl) begin
      rdata_next = ctrl_word;
    end else if (sel_stat) begin
      rdata_next = stat_word;
    end else if (sel_seen) begin
      rdata_next = seen_word;
    end else if (sel_accum) begin
      rdata_next = accum_word;
    end else if (sel_arm) begin
      rdata_next = arm_word;
    end else if (sel_clear) begin
      rdata_next = clear_word;
    end else begin
      rdata_next = `RFA_DATA_ZERO;
    end
  end

  // ****************************************
  // Read data register
  // ****************************************
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      rdata_out <= `RFA_DATA_ZERO;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= rd_in;
      if (rd_in) begin
        rdata_out <= rdata_next;
      end
    end
  end

endmodule

`default_nettype wire

// File: design/rfa_defines.vh
`ifndef RFA_DEFINES_VH
`define RFA_DEFINES_VH

// ****************************************
// Register offsets from module base
// ****************************************
`define RFA_OFF_CTRL 12'h000
`define RFA_OFF_STAT 12'h004
`define RFA_OFF_SEEN 12'h008
`define RFA_OFF_ACCUM 12'h00C
`define RFA_OFF_ARM 12'h010
`define RFA_OFF_CLEAR 12'h014
`define RFA_OFF_W 12

// ****************************************
// Field access kinds
// ****************************************
`define RFA_T_RW 3'h0
`define RFA_T_RO 3'h1
`define RFA_T_RC 3'h2
`define RFA_T_RWC 3'h3
`define RFA_T_W1C 3'h4
`define RFA_T_W1S 3'h5

// ****************************************
// Field layout and reset values
// ****************************************
`define RFA_FLD_LO 0
`define RFA_FLD_HI 7
`define RFA_ID_LO 8
`define RFA_ID_HI 15
`define RFA_RST_ZERO 1'h0
`define RFA_DATA_ZERO 32'h0000_0000

`endif

// File: design/rfa_field.v
`timescale 1ns/1ps
`default_nettype none
`include "rfa_defines.vh"

// ****************************************
// One register bit with a selectable access kind
// ****************************************
module rfa_field #(
  parameter [2:0] KIND = `RFA_T_RW,
  parameter [0:0] RST_VAL = `RFA_RST_ZERO
) (
  input wire clk_in,
  input wire nrst_in,
  input wire wr_in,
  input wire rd_in,
  input wire wbit_in,
  input wire hw_set_in,
  input wire hw_clr_in,
  output reg q_out
);

  reg q_next;

  always @* begin
    q_next = q_out;
    case (KIND)
      `RFA_T_RW: begin
        if (wr_in) begin
          q_next = wbit_in;
        end
      end
      `RFA_T_RO: begin
        q_next = RST_VAL;
      end
      `RFA_T_RC: begin
        if (rd_in) begin
          q_next = 1'b0;
        end
      end
      `RFA_T_RWC: begin
        if (wr_in) begin
          q_next = 1'b0;
        end
      end
      `RFA_T_W1C: begin
        if (wr_in && wbit_in) begin
          q_next = 1'b0;
        end
      end
      `RFA_T_W1S: begin
        if (hw_clr_in) begin
          q_next = 1'b0;
        end
        if (wr_in && wbit_in) begin
          q_next = 1'b1;
        end
      end
      default: begin
        q_next = q_out;
      end
    endcase
    // Hardware event wins over any clear
    if (hw_set_in && (KIND != `RFA_T_RW) && (KIND != `RFA_T_RO)) begin
      q_next = 1'b1;
    end
  end

  always @(posedge clk_in) begin
    if (!nrst_in) begin
      q_out <= RST_VAL;
    end else begin
      q_out <= q_next;
    end
  end

endmodule

`default_nettype wire
